//--- logic/pie_enable_bank.sv
// peripheral interrupt enable bank with ahb-lite register slave
// How it works
// [R1] with priority mode off, the global peripheral enable must also be set
// [R2] bit 7 gates the parallel slave interface read/write request
// [R3] bit 6 gates the converter completion request
// [R4] bit 5 gates the serial receive request
// [R5] bit 4 gates the serial transmit request
// [R6] bit 3 gates the sync serial port request
// [R7] bit 2 is unimplemented: reads zero, writes ignored
// [R8] bit 1 gates the timer two period match request
// [R9] bit 0 gates the timer one overflow request
// [R10] a second enable register covers the remaining sources
// [R11] request reaches the core only when pending flag and enables all agree
// [R12] reset clears every implemented enable bit
`default_nettype none
module pie_enable_bank
	import pie_pkg::*;
#(
	parameter int SRC2_W = 8
)
(
	// clock, reset, enable
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// pending flags from peripheral sources (same clock)
	input  wire logic [7:0]        pend_1,
	input  wire logic [SRC2_W-1:0] pend_2,
	// requests to the core
	output logic [7:0]             core_req_1,
	output logic [SRC2_W-1:0]      core_req_2,
	output logic                   core_req_any,
	// block interrupt
	output logic                   irq
);

	// register state
	logic [7:0]        en1_ff;
	logic [SRC2_W-1:0] en2_ff;
	logic [1:0]        ctl_ff;
	logic [1:0]        sts_ff;
	logic [1:0]        msk_ff;
	logic              any_ff;
	pie_bus_req_t      req_ff;
	logic [31:0]       rdata_ff;

	// bus address phase decode
	wire logic         acc_ok = hsel & hready & (htrans == PIE_HTRANS_NONSEQ || htrans == PIE_HTRANS_SEQ);
	wire pie_bus_req_t nxt_req = '{wr: acc_ok & hwrite, rd: acc_ok & ~hwrite, addr: haddr[7:0]};

	// data phase write strobes
	wire logic wr_en1 = req_ff.wr & (req_ff.addr == PIE_OFS_ENABLE_1);
	wire logic wr_en2 = req_ff.wr & (req_ff.addr == PIE_OFS_ENABLE_2);
	wire logic wr_ctl = req_ff.wr & (req_ff.addr == PIE_OFS_CONTROL);
	wire logic wr_sts = req_ff.wr & (req_ff.addr == PIE_OFS_STATUS);
	wire logic wr_msk = req_ff.wr & (req_ff.addr == PIE_OFS_MASK);

	// global gate: priority mode bypasses the global peripheral enable
	wire logic global_peripheral_irq_enable = ctl_ff[PIE_BIT_GLOBAL];
	wire logic priority_mode_enable         = ctl_ff[PIE_BIT_PRIORITY];
	wire logic gate_open = priority_mode_enable | global_peripheral_irq_enable; // [R1]

	// individual gating of register 1 sources
	wire logic [7:0] en1_impl = en1_ff & PIE_EN1_IMPL; // [R7]
	wire logic [7:0] gated_1  = pend_1 & en1_impl & {8{gate_open}}; // [R2] [R3] [R4] [R5] [R6] [R8] [R9] [R11]
	wire logic [SRC2_W-1:0] gated_2 = pend_2 & en2_ff & {SRC2_W{gate_open}}; // [R10] [R11]
	wire logic nxt_any = |gated_1 | |gated_2;

	// status events: request edges
	wire logic [1:0] evt;
	assign evt[PIE_EVT_REQ_RISE] = nxt_any & ~any_ff;
	assign evt[PIE_EVT_REQ_FALL] = ~nxt_any & any_ff;
	// write one clears, a new event wins
	wire logic [1:0] nxt_sts = (sts_ff & ~(wr_sts ? hwdata[1:0] : 2'h0)) | evt;

	// read mux
	logic [31:0] nxt_rdata;
	always_comb
	begin
		nxt_rdata = 32'h0;
		case (haddr[7:0])
			PIE_OFS_ENABLE_1: nxt_rdata[7:0]        = en1_impl; // [R7]
			PIE_OFS_ENABLE_2: nxt_rdata[SRC2_W-1:0] = en2_ff;
			PIE_OFS_CONTROL:  nxt_rdata[1:0]        = ctl_ff;
			PIE_OFS_PENDING:  nxt_rdata[7:0]        = pend_1;
			PIE_OFS_STATUS:   nxt_rdata[1:0]        = sts_ff;
			PIE_OFS_MASK:     nxt_rdata[1:0]        = msk_ff;
			PIE_OFS_REQUEST:  nxt_rdata[7:0]        = gated_1;
			default:          nxt_rdata             = 32'h0;
		endcase
	end

	// bus phase tracking and read data
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			req_ff   <= '0;
			rdata_ff <= 32'h0;
		end
		else if (clk_en)
		begin
			req_ff   <= nxt_req;
			rdata_ff <= (acc_ok & ~hwrite) ? nxt_rdata : 32'h0;
		end
	end

	// enable and control registers
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			en1_ff <= PIE_EN_RESET; // [R12]
			en2_ff <= '0; // [R12]
			ctl_ff <= PIE_CTL_RESET;
			msk_ff <= PIE_STS_RESET;
		end
		else if (clk_en)
		begin
			if (wr_en1)
				en1_ff <= hwdata[7:0] & PIE_EN1_IMPL; // [R7]
			if (wr_en2)
				en2_ff <= hwdata[SRC2_W-1:0];
			if (wr_ctl)
				ctl_ff <= hwdata[1:0];
			if (wr_msk)
				msk_ff <= hwdata[1:0];
		end
	end

	// outputs to core and status
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			core_req_1   <= 8'h00;
			core_req_2   <= '0;
			any_ff       <= 1'b0;
			sts_ff       <= PIE_STS_RESET;
		end
		else if (clk_en)
		begin
			core_req_1 <= gated_1; // [R11]
			core_req_2 <= gated_2;
			any_ff     <= nxt_any;
			sts_ff     <= nxt_sts;
		end
	end

	// bus answers and interrupt
	assign core_req_any = any_ff;
	assign hrdata       = rdata_ff;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign irq          = |(sts_ff & msk_ff);

endmodule
`default_nettype wire

//--- pkg/pie_pkg.sv
// package: register map, field positions and carriers for the peripheral interrupt enable bank
`default_nettype none
package pie_pkg;
	// register byte offsets on the ahb-lite bus
	localparam logic [7:0] PIE_OFS_ENABLE_1  = 8'h00;
	localparam logic [7:0] PIE_OFS_ENABLE_2  = 8'h04;
	localparam logic [7:0] PIE_OFS_CONTROL   = 8'h08;
	localparam logic [7:0] PIE_OFS_PENDING   = 8'h0C;
	localparam logic [7:0] PIE_OFS_STATUS    = 8'h10;
	localparam logic [7:0] PIE_OFS_MASK      = 8'h14;
	localparam logic [7:0] PIE_OFS_REQUEST   = 8'h18;

	// enable register 1 field positions
	localparam int PIE_BIT_PARALLEL  = 7;
	localparam int PIE_BIT_CONVERTER = 6;
	localparam int PIE_BIT_SER_RX    = 5;
	localparam int PIE_BIT_SER_TX    = 4;
	localparam int PIE_BIT_SYNC_SER  = 3;
	localparam int PIE_BIT_UNUSED    = 2;
	localparam int PIE_BIT_TIMER_TWO      = 1;
	localparam int PIE_BIT_TIMER_ONE      = 0;

	// control register field positions
	localparam int PIE_BIT_GLOBAL    = 0;
	localparam int PIE_BIT_PRIORITY  = 1;

	// implemented-bit masks and reset values
	localparam logic [7:0] PIE_EN1_IMPL  = 8'hFB;
	localparam logic [7:0] PIE_EN2_IMPL  = 8'hFF;
	localparam logic [7:0] PIE_EN_RESET  = 8'h00;
	localparam logic [1:0] PIE_CTL_RESET = 2'h0;
	localparam logic [1:0] PIE_STS_RESET = 2'h0;

	// status / mask bit positions
	localparam int PIE_EVT_REQ_RISE  = 0;
	localparam int PIE_EVT_REQ_FALL  = 1;

	// ahb-lite encodings
	localparam logic [1:0] PIE_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] PIE_HTRANS_SEQ    = 2'h3;

	// registered address phase of one bus transfer
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} pie_bus_req_t;
endpackage
`default_nettype wire

//--- sim/pie_enable_bank_properties.sv
// checker: port-level properties of the enable bank
`default_nettype none
module pie_enable_bank_properties import pie_pkg::*; #(parameter int SRC2_W = 8) (
	input wire logic ref_clk, reset, clk_en, hsel, hwrite, hready, irq, core_req_any,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr, hwdata, hrdata,
	input wire logic [7:0] pend_1, core_req_1,
	input wire logic [SRC2_W-1:0] pend_2, core_req_2
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_ff, rd_ff;
	logic [7:0] wa_ff, en_ff;
	logic [1:0] ctl_ff;
	wire tk = hsel && hready && htrans[1];
	// shadow of enable 1 and control
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			{wr_ff, rd_ff, wa_ff, en_ff, ctl_ff} <= '0;
		end
		else if (clk_en)
		begin
			wr_ff <= tk && hwrite;
			rd_ff <= tk && !hwrite && haddr[7:0] == PIE_OFS_ENABLE_1;
			wa_ff <= haddr[7:0];
			if (wr_ff && wa_ff == PIE_OFS_ENABLE_1)
				en_ff <= hwdata[7:0] & PIE_EN1_IMPL;
			else if (wr_ff && wa_ff == PIE_OFS_CONTROL)
				ctl_ff <= hwdata[1:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_gate_exact: assert property (clk_en |=> core_req_1 == ($past(pend_1) & $past(en_ff) & {8{|$past(ctl_ff)}}))
		else $error("gate");
	a_gate_global: assert property (clk_en && ctl_ff == 2'h0 |=> core_req_1 == 8'h00)
		else $error("global");
	a_par_gate: assert property (clk_en && !en_ff[7] |=> !core_req_1[7])
		else $error("bit7");
	a_gate_two: assert property (clk_en |=> (core_req_2 & ~$past(pend_2)) == '0)
		else $error("reg2");
	a_bit2_dead: assert property (core_req_1[2] == 1'b0)
		else $error("bit2");
	a_any_or: assert property (core_req_any == |{core_req_1, core_req_2})
		else $error("any");
	a_en_readback: assert property (rd_ff |-> hrdata == {24'h0, $past(en_ff)})
		else $error("readback");
	a_reset_clear: assert property (disable iff (1'b0) reset |=> core_req_1 == 8'h00 && !irq)
		else $error("reset");
endmodule
bind pie_enable_bank pie_enable_bank_properties #(.SRC2_W(SRC2_W)) props_inst (.ref_clk, .reset, .clk_en, .hsel,
	.hwrite, .hready, .irq, .core_req_any, .htrans, .haddr, .hwdata, .hrdata, .pend_1, .core_req_1, .pend_2,
	.core_req_2);
`default_nettype wire

//--- sim/pie_src_model.sv
// partner: peripheral pending-flag sources
`default_nettype none
module pie_src_model (
	input wire logic ref_clk,
	input wire logic [7:0] set_1, set_2,
	output logic [7:0] pend_1, pend_2
);
	timeunit 1ns;
	timeprecision 1ps;
	// flags follow the source events one edge later
	always_ff @(posedge ref_clk) {pend_1, pend_2} <= {set_1, set_2};
endmodule
`default_nettype wire

//--- sim/tb.sv
// testbench: bus, gating and interrupt scenarios
`default_nettype none
module tb import pie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, reset = 1, clk_en = 1, hsel = 0, hwrite = 0, hreadyout, hresp, core_req_any, irq;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0] set_1 = 8'h00, set_2 = 8'h00, pend_1, pend_2, core_req_1, core_req_2;
	int err_count = 0, checked = 0, cyc = 0;
	pie_enable_bank pie_enable_bank_inst (.ref_clk, .reset, .clk_en, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pend_1, .pend_2,
		.core_req_1, .core_req_2, .core_req_any, .irq);
	pie_src_model pie_src_model_inst (.ref_clk, .set_1, .set_2, .pend_1, .pend_2);
	initial forever #20 ref_clk = ~ref_clk;
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			print_verdict;
		end
	end
	task automatic print_verdict;
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one transfer: address phase and data phase each held until hready, read data taken at its edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= PIE_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		// let a write reach the registered outputs before anyone looks
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic t_bits;
		bus(0, PIE_OFS_ENABLE_1, 0); chk(rd, 0);
		bus(0, 8'h1C, 0); chk(rd, 0);
		set_1 <= 8'hFF;
		bus(1, PIE_OFS_CONTROL, 1);
		for (int i = 0; i < 8; i++)
		begin
			bus(1, PIE_OFS_ENABLE_1, 1 << i);
			bus(0, PIE_OFS_ENABLE_1, 0); chk(rd, (1 << i) & 8'hFB);
			chk(core_req_1, (1 << i) & 8'hFB);
		end
	endtask
	task automatic t_global;
		bus(1, PIE_OFS_ENABLE_1, 8'hFF);
		bus(1, PIE_OFS_CONTROL, 0); chk(core_req_1, 0);
		chk(core_req_any, 0);
		bus(1, PIE_OFS_CONTROL, 2); chk(core_req_1, 8'hFB);
		set_2 <= 8'h5A;
		bus(1, PIE_OFS_ENABLE_2, 8'hFF); chk(core_req_2, 8'h5A);
		chk(core_req_any, 1);
	endtask
	task automatic t_irq;
		bus(1, PIE_OFS_MASK, 1);
		set_1 <= 8'h00;
		set_2 <= 8'h00;
		repeat (4) @(posedge ref_clk);
		bus(1, PIE_OFS_STATUS, 3); chk(irq, 0);
		set_1 <= 8'h01;
		repeat (4) @(posedge ref_clk);
		chk(irq, 1);
		bus(1, PIE_OFS_MASK, 0); chk(irq, 0);
		bus(1, PIE_OFS_MASK, 1); chk(irq, 1);
		bus(1, PIE_OFS_STATUS, 1); chk(irq, 0);
	endtask
	// clock enable low freezes the gated requests
	task automatic t_freeze;
		clk_en <= 1'b0;
		set_1 <= 8'h00;
		repeat (4) @(posedge ref_clk);
		chk(core_req_1, 8'h01);
		clk_en <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(core_req_1, 8'h00);
		chk(core_req_any, 0);
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_bits;
		t_global;
		t_irq;
		t_freeze;
		print_verdict;
	end
endmodule
`default_nettype wire
